// ==== design/trigger_debounce_filter.sv ====
// trigger input debounce filters with an avalon-mm register slave
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
`include "trig_filter_map.svh"
module trigger_debounce_filter #(
    parameter int NUM_BUSED = 8,
    parameter int SLOW_DIV  = `SLOW_DIV
) (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    // avalon-mm slave
    input  wire logic                      read,
    input  wire logic                      write,
    input  wire logic [7:0]                address,
    input  wire logic [31:0]               writedata,
    input  wire logic [3:0]                byteenable,
    output logic [31:0]                    readdata,
    output logic                           waitrequest,
    // backplane trigger pins
    input  wire logic [NUM_BUSED-1:0]      trig_bus_in,
    input  wire logic                      star_in,
    input  wire logic                      dstar_a_in,
    input  wire logic                      dstar_b_in,
    output logic                           dstar_c_out,
    // filtered triggers toward the acquisition logic
    output logic [NUM_BUSED-1:0]           internal_timing_trigger_line,
    output logic                           star_trig,
    output logic                           dstar_a_clk,
    output logic                           dstar_b_trig,
    // reference clock choice
    output logic [1:0]                     ref_clk_sel
);
    import trig_filter_pkg::*;

    localparam int NCH = NUM_BUSED + 3;
    localparam int CH_STAR = NUM_BUSED;
    localparam int CH_DA = NUM_BUSED + 1;
    localparam int CH_DB = NUM_BUSED + 2;

    initial begin
        if (NUM_BUSED != 8)
            $error("bused trigger count must be eight");
        if (SLOW_DIV < 3 || SLOW_DIV > 65535)
            $error("slow divider out of range");
    end

    // pins, one vector; channels NUM_BUSED.. are star, dstar a, dstar b
    logic [NCH-1:0] pin_in;
    logic [NCH-1:0] s1_reg;
    logic [NCH-1:0] s2_reg;
    logic [NCH-1:0] s3_reg;
    logic [NCH-1:0] lvl_reg;
    logic [NCH-1:0] filt;
    chan_cfg_t      cfg_reg [NCH];
    logic [NCH-1:0] tick_ch;
    logic [15:0]    n_ch [NCH];

    assign pin_in = {dstar_b_in, dstar_a_in, star_in, trig_bus_in};

    // three-stage synchroniser; stage two and three must agree before a change counts
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lvl_reg <= '0;
        end else begin
            lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
        end
    end

    // timebases, all counted from core_clk, the onboard oscillator
    logic [15:0] slow_cnt_reg;
    logic [15:0] cust_cnt_reg;
    logic [15:0] custdiv_reg;
    logic        slow_tick;
    logic        cust_tick;
    logic        fast_tick;

    assign fast_tick = 1'b1;
    assign slow_tick = (slow_cnt_reg == 16'(SLOW_DIV - 1));
    assign cust_tick = (cust_cnt_reg >= custdiv_reg - 16'h0001);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            slow_cnt_reg <= 16'h0000;
        end else if (slow_tick) begin
            slow_cnt_reg <= 16'h0000;
        end else begin
            slow_cnt_reg <= slow_cnt_reg + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cust_cnt_reg <= 16'h0000;
        end else if (cust_tick) begin
            cust_cnt_reg <= 16'h0000;
        end else begin
            cust_cnt_reg <= cust_cnt_reg + 16'h0001;
        end
    end

    // per-channel filters
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            always_comb begin
                unique case (cfg_reg[g].setting)
                    SET_SHORT: begin
                        tick_ch[g] = fast_tick;
                        n_ch[g] = `N_SHORT;
                    end
                    SET_MEDIUM: begin
                        tick_ch[g] = fast_tick;
                        n_ch[g] = `N_MEDIUM;
                    end
                    SET_HIGH: begin
                        tick_ch[g] = slow_tick;
                        n_ch[g] = `N_HIGH;
                    end
                    SET_CUSTOM: begin
                        tick_ch[g] = cust_tick;
                        n_ch[g] = cfg_reg[g].count;
                    end
                endcase
            end

            debounce_cell u_cell (
                .core_clk (core_clk),
                .resetn   (resetn),
                .lvl      (lvl_reg[g]),
                .tick     (tick_ch[g]),
                .enable   (cfg_reg[g].enable),
                .count    (n_ch[g]),
                .out_reg  (filt[g])
            );
        end
    endgenerate

    assign internal_timing_trigger_line = filt[NUM_BUSED-1:0];
    assign star_trig = filt[CH_STAR];
    assign dstar_a_clk = filt[CH_DA];
    assign dstar_b_trig = filt[CH_DB];

    // avalon slave: one wait cycle, writes land and read data stands at the release edge
    av_req_t     req;
    logic        ack_reg;
    logic        cfg_hit;
    logic [3:0]  cfg_idx;
    logic [31:0] wmask;
    logic [31:0] rd_next;
    logic [31:0] rd_reg;
    logic [8:0]  dstarc_reg;
    logic [1:0]  ref_reg;
    logic        wr_go;

    assign req = '{read: read, write: write, address: address, writedata: writedata, byteenable: byteenable};
    assign waitrequest = (req.read | req.write) & ~ack_reg;
    assign wr_go = req.write & ack_reg;
    assign cfg_idx = req.address[5:2];
    assign cfg_hit = (req.address[7:6] == 2'b00) && (req.address[1:0] == 2'b00)
                     && (cfg_idx < 4'(NCH));
    assign wmask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                    {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction : merge

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (req.read | req.write) & ~ack_reg;
        end
    end

    function automatic logic [31:0] cfg_word(input chan_cfg_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`CFG_EN_BIT] = c.enable;
        w[`CFG_SET_LSB +: 2] = c.setting;
        w[`CFG_N_LSB +: 16] = c.count;
        cfg_word = w;
    endfunction : cfg_word

    // per-channel config registers; all disabled at reset
    generate
        for (g = 0; g < NCH; g++) begin : g_cfg
            logic [31:0] w;
            assign w = merge(cfg_word(cfg_reg[g]), req.writedata, wmask);
            always_ff @(posedge core_clk or negedge resetn) begin
                if (!resetn) begin
                    cfg_reg[g] <= '0;
                end else if (wr_go && cfg_hit && cfg_idx == 4'(g)) begin
                    cfg_reg[g].enable <= w[`CFG_EN_BIT];
                    cfg_reg[g].setting <= filt_setting_t'(w[`CFG_SET_LSB +: 2]);
                    cfg_reg[g].count <= w[`CFG_N_LSB +: 16];
                end
            end
        end
    endgenerate

    // a zero divider would stall the custom timebase, so it is served as one
    logic [31:0] custdiv_w;
    assign custdiv_w = merge({16'h0000, custdiv_reg}, req.writedata, wmask);

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            custdiv_reg <= `CUSTDIV_RESET;
        end else if (wr_go && req.address == `CUSTDIV_OFS) begin
            custdiv_reg <= (custdiv_w[15:0] == 16'h0000) ? 16'h0001 : custdiv_w[15:0];
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dstarc_reg <= 9'h000;
        end else if (wr_go && req.address == `DSTARC_OFS) begin
            dstarc_reg <= 9'(merge({23'h0, dstarc_reg}, req.writedata, wmask));
        end
    end

    // the legacy 10 mhz clock code is refused; the old choice stays
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ref_reg <= `REF_ONBOARD;
        end else if (wr_go && req.address == `REFCLK_OFS && req.byteenable[0]
                     && req.writedata[1:0] != `REF_CLK10
                     && req.writedata[1:0] <= `REF_CLK100) begin
            ref_reg <= req.writedata[1:0];
        end
    end

    assign ref_clk_sel = ref_reg;

    // dstar c drives a chosen filtered trigger toward the timing slot; no star drive exists
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            dstar_c_out <= 1'b0;
        end else if (dstarc_reg[`DSTARC_EN_BIT] && dstarc_reg[3:0] < 4'(NCH)) begin
            dstar_c_out <= filt[dstarc_reg[3:0]];
        end else begin
            dstar_c_out <= 1'b0;
        end
    end

    always_comb begin
        rd_next = 32'h0000_0000;
        if (cfg_hit) begin
            rd_next = cfg_word(cfg_reg[cfg_idx]);
        end else begin
            unique case (req.address)
                `STATUS_OFS: rd_next = 32'(filt);
                `RAW_OFS:    rd_next = 32'(lvl_reg);
                `DSTARC_OFS: rd_next = {23'h0, dstarc_reg};
                `REFCLK_OFS: rd_next = {30'h0, ref_reg};
                `CUSTDIV_OFS: rd_next = {16'h0, custdiv_reg};
                default:     rd_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_reg <= 32'h0000_0000;
        end else if (req.read && !ack_reg) begin
            rd_reg <= rd_next;
        end
    end

    assign readdata = rd_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_wait_one_cycle: assert property ((read || write) && !ack_reg |-> waitrequest ##1 !waitrequest)
        else $error("slave did not answer after one wait cycle");
    a_ref_no_clk10: assert property (ref_clk_sel != `REF_CLK10)
        else $error("legacy clock selected as reference");
    a_filters_off: assert property ($rose(resetn) |-> !cfg_reg[0].enable && !cfg_reg[CH_DB].enable)
        else $error("filter enabled out of reset");
    a_slow_period: assert property (slow_tick |=> !slow_tick [*2])
        else $error("slow timebase ticks too often");
    a_line_map: assert property (!cfg_reg[7].enable |=> internal_timing_trigger_line[7] == $past(lvl_reg[7]))
        else $error("timing lines not mapped to bused pins");
    a_dstarc_off: assert property (!dstarc_reg[`DSTARC_EN_BIT] |=> !dstar_c_out)
        else $error("dstar c driven while disabled");
    a_sync_agree: assert property (s2_reg[0] == s3_reg[0] |=> lvl_reg[0] == $past(s3_reg[0]))
        else $error("agreed level not taken");
    a_short_count: assert property (cfg_reg[0].setting == SET_SHORT |-> n_ch[0] == 16'h0009)
        else $error("short setting count wrong");

    c_write_cfg: cover property (wr_go && cfg_hit);
    c_star_rise: cover property ($rose(star_trig));
    c_ref_refused: cover property (wr_go && req.address == `REFCLK_OFS && req.writedata[1:0] == `REF_CLK10);

endmodule : trigger_debounce_filter

// ==== common/trig_filter_map.svh ====
// offsets, field positions, reset values and timing counts of the trigger filter
`ifndef TRIG_FILTER_MAP_SVH
`define TRIG_FILTER_MAP_SVH

// register byte offsets; channel config registers sit at CFG_BASE + 4 * channel
`define CFG_BASE        8'h00
`define STATUS_OFS      8'h40
`define RAW_OFS         8'h44
`define DSTARC_OFS      8'h48
`define REFCLK_OFS      8'h4C
`define CUSTDIV_OFS     8'h50

// channel config fields
`define CFG_EN_BIT      0
`define CFG_SET_LSB     4
`define CFG_N_LSB       16
`define CFG_RESET       32'h0000_0000

// dstar c source select fields
`define DSTARC_SRC_LSB  0
`define DSTARC_EN_BIT   8

// preset sample counts
`define N_SHORT         16'h0009
`define N_MEDIUM        16'h0200
`define N_HIGH          16'h0100

// reference clock choice codes
`define REF_ONBOARD     2'h0
`define REF_CLK100      2'h1
`define REF_CLK10       2'h2

// timebases, derived from the onboard oscillator on core_clk
`define CORE_HZ         20000000
`define SLOW_TB_HZ      100000
`define SLOW_DIV        (`CORE_HZ / `SLOW_TB_HZ)
`define FAST_DIV        1
`define CUSTDIV_RESET   16'h0001

`endif

// ==== common/trig_filter_pkg.sv ====
// types shared by the trigger filter design
package trig_filter_pkg;

    typedef enum logic [1:0] {
        SET_SHORT  = 2'h0,
        SET_MEDIUM = 2'h1,
        SET_HIGH   = 2'h2,
        SET_CUSTOM = 2'h3
    } filt_setting_t;

    typedef struct packed {
        logic          enable;
        filt_setting_t setting;
        logic [15:0]   count;
    } chan_cfg_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } av_req_t;

endpackage : trig_filter_pkg

// ==== design/debounce_cell.sv ====
// one debounce filter: n consecutive timebase samples at a new level pass it
`timescale 1ns/1ns
module debounce_cell (
    // clock and reset
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    // sampled input and timebase
    input  wire logic                   lvl,
    input  wire logic                   tick,
    input  wire logic                   enable,
    input  wire logic [15:0]            count,
    // filtered level
    output logic                        out_reg
);
    import trig_filter_pkg::*;

    logic [15:0] cnt_reg;
    logic [16:0] cnt_inc;
    logic        reached;

    assign cnt_inc = {1'b0, cnt_reg} + 17'h0_0001;
    // a count of zero is served as one
    assign reached = (cnt_inc >= {1'b0, count});

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 16'h0000;
        end else if (!enable) begin
            cnt_reg <= 16'h0000;
        end else if (tick) begin
            if (lvl != out_reg && !reached) begin
                cnt_reg <= cnt_inc[15:0];
            end else begin
                cnt_reg <= 16'h0000;
            end
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            out_reg <= 1'b0;
        end else if (!enable) begin
            out_reg <= lvl;
        end else if (tick && lvl != out_reg && reached) begin
            out_reg <= lvl;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    a_glitch_restart: assert property (enable && tick && lvl == out_reg |=> cnt_reg == 16'h0000)
        else $error("count not restarted by a glitch");
    a_pass_after_n: assert property ($past(enable) && enable && $changed(out_reg)
            |-> $past(tick) && $past(cnt_inc) >= {1'b0, $past(count)})
        else $error("edge passed before n samples");
    a_bypass_follow: assert property (!enable |=> out_reg == $past(lvl))
        else $error("disabled filter does not follow input");
    a_tick_only: assert property (enable && !tick |=> $stable(cnt_reg))
        else $error("count moved without a timebase edge");
    c_edge_passed: cover property (enable && tick && reached && lvl != out_reg);

endmodule : debounce_cell

// ==== verif/backplane_model.sv ====
// chassis backplane and timing controller model driving the trigger pins
`timescale 1ns/1ns
module backplane_model (
    // trigger pins toward the module
    output logic [7:0] trig_bus_in,
    output logic       star_in,
    output logic       dstar_a_in,
    output logic       dstar_b_in,
    // line driven by the module toward the timing slot
    input  wire logic  dstar_c_out,
    // slot sync clock
    output logic       sync100
);
    logic [10:0] lines_reg;

    initial lines_reg = 11'h000;
    // the controller drives a and b into the slot and only listens on c
    assign {dstar_b_in, dstar_a_in, star_in, trig_bus_in} = lines_reg;

    // free running 10 mhz with a short high phase, unrelated to core_clk
    initial begin
        sync100 = 1'b0;
        forever begin
            sync100 = 1'b1;
            #10;
            sync100 = 1'b0;
            #90;
        end
    end

    // called right after a rising edge, so the pin moves with that edge's updates
    task automatic drive(input int ch, input logic v);
        lines_reg[ch] <= v;
    endtask : drive
endmodule : backplane_model

// ==== verif/tb_trigger_debounce_filter.sv ====
// self-checking bench for the trigger debounce filter
`timescale 1ns/1ns
`include "trig_filter_map.svh"
module tb_trigger_debounce_filter;
    import trig_filter_pkg::*;
    localparam int SDIV = 4;
    logic        core_clk;
    logic        resetn;
    av_req_t     req;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [7:0]  trig_bus_in;
    logic        star_in;
    logic        dstar_a_in;
    logic        dstar_b_in;
    logic        dstar_c_out;
    logic [7:0]  internal_timing_trigger_line;
    logic        star_trig;
    logic        dstar_a_clk;
    logic        dstar_b_trig;
    logic [1:0]  ref_clk_sel;
    logic [10:0] filt;
    int          mismatches;
    int          checks;

    assign filt = {dstar_b_trig, dstar_a_clk, star_trig, internal_timing_trigger_line};

    trigger_debounce_filter #(.NUM_BUSED(8), .SLOW_DIV(SDIV)) trigger_debounce_filter_i (
        .core_clk(core_clk), .resetn(resetn), .read(req.read), .write(req.write),
        .address(req.address), .writedata(req.writedata), .byteenable(req.byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .trig_bus_in(trig_bus_in),
        .star_in(star_in), .dstar_a_in(dstar_a_in), .dstar_b_in(dstar_b_in),
        .dstar_c_out(dstar_c_out), .internal_timing_trigger_line(internal_timing_trigger_line),
        .star_trig(star_trig), .dstar_a_clk(dstar_a_clk), .dstar_b_trig(dstar_b_trig),
        .ref_clk_sel(ref_clk_sel));

    backplane_model backplane_model_i (
        .trig_bus_in(trig_bus_in), .star_in(star_in), .dstar_a_in(dstar_a_in),
        .dstar_b_in(dstar_b_in), .dstar_c_out(dstar_c_out), .sync100());

    always #25 core_clk = ~core_clk;

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic timeout;
        mismatches++;
        $display("unexpected at %0t: wait bound used up, got %h expected %h", $time, 1'b0, 1'b1);
        complete_run();
    endtask : timeout

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    task automatic check_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: level %h expected %h", $time, got, exp);
        end
    endtask : check_bit

    // holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int i;
        @(posedge core_clk);
        req <= '{read: rd, write: ~rd, address: a, writedata: d, byteenable: 4'hF};
        for (i = 0; i < 20; i++) begin
            @(posedge core_clk);
            if (waitrequest === 1'b0)
                break;
        end
        q = readdata;
        req <= '0;
        if (i == 20)
            timeout();
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b0, a, d, q);
    endtask : wr

    task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b1, a, 32'h0000_0000, q);
        check_word(q, exp);
    endtask : rd_check

    function automatic logic [31:0] cfg(input filt_setting_t s, input logic [15:0] n);
        return (32'(n) << `CFG_N_LSB) | (32'(s) << `CFG_SET_LSB) | 32'h1;
    endfunction : cfg

    // counts edges until the filtered channel shows v
    task automatic settle(input int ch, input logic v, output int d);
        for (d = 0; d < 3000; d++) begin
            @(posedge core_clk);
            if (filt[ch] === v)
                return;
        end
        timeout();
    endtask : settle

    task automatic edge_delay(input int ch, input logic v, output int d);
        @(posedge core_clk);
        backplane_model_i.drive(ch, v);
        settle(ch, v, d);
    endtask : edge_delay

    // high for width cycles; watches the output for win cycles
    task automatic pulse(input int ch, input int width, input int win, input logic exp);
        logic seen;
        int   i;
        seen = 1'b0;
        @(posedge core_clk);
        backplane_model_i.drive(ch, 1'b1);
        for (i = 0; i < win; i++) begin
            @(posedge core_clk);
            if (i == width - 1)
                backplane_model_i.drive(ch, 1'b0);
            seen = seen | filt[ch];
        end
        check_bit(seen, exp);
        settle(ch, 1'b0, i);
    endtask : pulse

    task automatic t_reset;
        for (int ch = 0; ch < 11; ch++)
            rd_check(`CFG_BASE + 8'(4 * ch), `CFG_RESET);
        rd_check(8'h60, 32'h0000_0000);
        wr(`REFCLK_OFS, 32'(`REF_CLK10));
        rd_check(`REFCLK_OFS, 32'(`REF_ONBOARD));
        wr(`REFCLK_OFS, 32'(`REF_CLK100));
        rd_check(`REFCLK_OFS, 32'(`REF_CLK100));
        check_word(32'(ref_clk_sel), 32'(`REF_CLK100));
    endtask : t_reset

    task automatic t_bypass;
        int d;
        for (int ch = 0; ch < 11; ch++) begin
            edge_delay(ch, 1'b1, d);
            check_bit(d <= 6, 1'b1);
            check_word(32'(filt), 32'h1 << ch);
            rd_check(`STATUS_OFS, 32'h1 << ch);
            rd_check(`RAW_OFS, 32'h1 << ch);
            edge_delay(ch, 1'b0, d);
        end
        pulse(3, 2, 12, 1'b1);
    endtask : t_bypass

    task automatic t_short;
        int db;
        int de;
        logic seen;
        wr(`CFG_BASE, cfg(SET_SHORT, 16'h0000));
        pulse(0, 8, 30, 1'b0);
        pulse(0, 9, 30, 1'b1);
        pulse(1, 3, 12, 1'b1);
        // two short runs around a gap that survives the synchroniser
        seen = 1'b0;
        for (int i = 0; i < 40; i++) begin
            @(posedge core_clk);
            backplane_model_i.drive(0, (i < 6) || (i >= 9 && i < 15));
            seen = seen | filt[0];
        end
        check_bit(seen, 1'b0);
        edge_delay(1, 1'b1, db);
        edge_delay(0, 1'b1, de);
        check_bit((de - db) >= 8 && (de - db) <= 9, 1'b1);
        edge_delay(1, 1'b0, db);
        edge_delay(0, 1'b0, de);
        check_bit((de - db) >= 8 && (de - db) <= 9, 1'b1);
    endtask : t_short

    task automatic t_long;
        wr(`CFG_BASE + 8'h20, cfg(SET_MEDIUM, 16'h0000));
        pulse(8, 511, 560, 1'b0);
        pulse(8, 512, 560, 1'b1);
        wr(`CFG_BASE + 8'h24, cfg(SET_HIGH, 16'h0000));
        pulse(9, 255 * SDIV, 260 * SDIV, 1'b0);
        pulse(9, 256 * SDIV, 260 * SDIV, 1'b1);
    endtask : t_long

    task automatic t_custom;
        int d;
        wr(`CUSTDIV_OFS, 32'h0000_0000);
        rd_check(`CUSTDIV_OFS, 32'h0000_0001);
        wr(`CUSTDIV_OFS, 32'h0000_0003);
        wr(`CFG_BASE + 8'h28, cfg(SET_CUSTOM, 16'h0005));
        rd_check(`CFG_BASE + 8'h28, cfg(SET_CUSTOM, 16'h0005));
        pulse(10, 9, 40, 1'b0);
        pulse(10, 15, 40, 1'b1);
        wr(`DSTARC_OFS, 32'h0000_010A);
        rd_check(`DSTARC_OFS, 32'h0000_010A);
        edge_delay(10, 1'b1, d);
        repeat (3) @(posedge core_clk);
        check_bit(dstar_c_out, 1'b1);
        wr(`DSTARC_OFS, 32'h0000_000A);
        repeat (3) @(posedge core_clk);
        check_bit(dstar_c_out, 1'b0);
        edge_delay(10, 1'b0, d);
    endtask : t_custom

    // a reset in mid-run must bring channels 0 and 10, the custom divider and the reference choice back to their power-on state
    task automatic t_rereset;
        @(posedge core_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge core_clk);
        resetn <= 1'b1;
        rd_check(`CFG_BASE, `CFG_RESET);
        rd_check(`CFG_BASE + 8'h28, `CFG_RESET);
        rd_check(`CUSTDIV_OFS, 32'(`CUSTDIV_RESET));
        check_word(32'(ref_clk_sel), 32'(`REF_ONBOARD));
    endtask : t_rereset

    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        req = '0;
        mismatches = 0;
        checks = 0;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        t_reset();
        t_bypass();
        t_short();
        t_long();
        t_custom();
        t_rereset();
        complete_run();
    end
endmodule : tb_trigger_debounce_filter
